//--- logic/pag_port.sv
// Purpose: Eight-pin bidirectional general-purpose port with analog and peripheral sharing.
// Assumes: Register accesses come from logic on core_clk; pads are asynchronous.
// Notes: Pad drive and read data are registered, one cycle after their cause.
`timescale 1ns/1ps
`include "pag_cfg.svh"
module pag_port
    import pag_pkg::*;
#(
    parameter int WIDTH = `PAG_WIDTH,
    parameter logic [7:0] SLEW_RESET = `PAG_SLEW_RESET
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wr_strobe,
    input wire pag_reg_sel_t wr_sel,
    input wire logic [7:0] wr_data,
    input wire pag_reg_sel_t rd_sel,
    output logic [7:0] rd_data,
    input wire logic osc_uses_pin_six,
    input wire logic osc_uses_pin_seven,
    input wire logic [7:0] comparator_one_control,
    input wire logic [7:0] comparator_two_control,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic [7:0] periph_enable,
    input wire logic [7:0] periph_drive,
    input wire logic [7:0] periph_drive_en,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_analog_en,
    output logic [7:0] pad_comparator_en,
    output logic [7:0] pad_slew_limit,
    output logic timer_zero_clock_input
);
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] pag_free_mask(input logic osc6, input logic osc7);
        logic [7:0] m;
        m = `PAG_ALL_ONES;
        m[`PAG_PIN_SIX] = ~osc6;
        m[`PAG_PIN_SEVEN] = ~osc7;
        return m;
    endfunction

    // ------------------------------------------------------------------------
    // Pad synchroniser
    // ------------------------------------------------------------------------
    pag_pin_if #(.WIDTH(WIDTH)) pins ();

    assign pins.raw = pad_in;

    pag_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .pins(pins)
    );

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    logic [7:0] pin_direction_reg;
    logic [7:0] pin_direction_next;
    logic [7:0] output_latch_reg;
    logic [7:0] output_latch_next;
    logic [7:0] analog_select_reg;
    logic [7:0] analog_select_next;
    logic [7:0] slew_rate_reg;
    logic [7:0] slew_rate_next;
    logic [7:0] free_mask;
    logic [7:0] pin_level;

    assign free_mask = pag_free_mask(osc_uses_pin_six, osc_uses_pin_seven);

    always_comb begin
        pin_direction_next = pin_direction_reg;
        output_latch_next = output_latch_reg;
        analog_select_next = analog_select_reg;
        slew_rate_next = slew_rate_reg;
        if (wr_strobe) begin
            case (wr_sel)
                PAG_SEL_DIRECTION: begin
                    pin_direction_next = wr_data;
                end
                PAG_SEL_LEVEL: begin
                    output_latch_next = wr_data;
                end
                PAG_SEL_LATCH: begin
                    output_latch_next = wr_data;
                end
                PAG_SEL_ANALOG: begin
                    analog_select_next = wr_data & `PAG_ANALOG_MASK;
                end
                PAG_SEL_SLEW: begin
                    slew_rate_next = wr_data;
                end
                default: begin
                    pin_direction_next = pin_direction_reg;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_direction_reg <= `PAG_DIR_RESET;
            output_latch_reg <= `PAG_LATCH_RESET;
            analog_select_reg <= `PAG_ANALOG_RESET;
            slew_rate_reg <= SLEW_RESET;
        end else begin
            pin_direction_reg <= pin_direction_next;
            output_latch_reg <= output_latch_next;
            analog_select_reg <= analog_select_next;
            slew_rate_reg <= slew_rate_next;
        end
    end

    // Analog pins read zero digitally; pin four has no analog select and stays digital.
    assign pin_level = pins.synced & ~analog_select_reg & free_mask;

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    always_comb begin
        case (rd_sel)
            PAG_SEL_DIRECTION: begin
                rd_data_next = pin_direction_reg & free_mask;
            end
            PAG_SEL_LEVEL: begin
                rd_data_next = pin_level;
            end
            PAG_SEL_LATCH: begin
                rd_data_next = output_latch_reg & free_mask;
            end
            PAG_SEL_ANALOG: begin
                rd_data_next = analog_select_reg;
            end
            PAG_SEL_SLEW: begin
                rd_data_next = slew_rate_reg;
            end
            default: begin
                rd_data_next = `PAG_ZERO_BYTE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg <= `PAG_ZERO_BYTE;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

    // ------------------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------------------
    logic [7:0] pad_out_reg;
    logic [7:0] pad_out_next;
    logic [7:0] pad_oe_reg;
    logic [7:0] pad_oe_next;
    logic [7:0] pad_cmp_reg;
    logic [7:0] pad_cmp_next;
    logic cmp_one_on;
    logic cmp_two_on;

    assign cmp_one_on = comparator_one_control[`PAG_CMP_OUT_EN_BIT];
    assign cmp_two_on = comparator_two_control[`PAG_CMP_OUT_EN_BIT];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Analog mode does not gate the driver; direction and the oscillator free mask do.
            pad_oe_next[i] = ~pin_direction_reg[i] & free_mask[i];
            pad_out_next[i] = output_latch_reg[i];
        end
        if (cmp_one_on && !pin_direction_reg[`PAG_PIN_FOUR]) begin
            pad_out_next[`PAG_PIN_FOUR] = comparator_one_output;
        end
        if (cmp_two_on && !pin_direction_reg[`PAG_PIN_FIVE]) begin
            pad_out_next[`PAG_PIN_FIVE] = comparator_two_output;
        end
        for (int i = 0; i < 8; i++) begin
            if (periph_enable[i]) begin
                pad_oe_next[i] = periph_drive_en[i] & free_mask[i];
                pad_out_next[i] = periph_drive[i];
            end
        end
        // Comparator controls steer pins 0 to 5 to the comparator pad path.
        pad_cmp_next = `PAG_ZERO_BYTE;
        if (cmp_one_on || cmp_two_on) begin
            pad_cmp_next = `PAG_COMPARATOR_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pad_out_reg <= `PAG_ZERO_BYTE;
            pad_oe_reg <= `PAG_ZERO_BYTE;
            pad_cmp_reg <= `PAG_ZERO_BYTE;
        end else begin
            pad_out_reg <= pad_out_next;
            pad_oe_reg <= pad_oe_next;
            pad_cmp_reg <= pad_cmp_next;
        end
    end

    assign pad_out = pad_out_reg;
    assign pad_oe = pad_oe_reg;
    assign pad_comparator_en = pad_cmp_reg;
    assign pad_analog_en = analog_select_reg;
    assign pad_slew_limit = slew_rate_reg;
    assign timer_zero_clock_input = pins.synced[`PAG_PIN_FOUR];
endmodule

//--- logic/pag_cfg.svh
// Purpose: Constants for the eight-pin bidirectional general-purpose port.
// Assumes: One clock, core_clk at 200 MHz; asynchronous active-low reset.
// Notes: Port geometry, field masks and reset values only; the types live in pag_pkg.
//
// How it works
// - One port of eight pins, each usable as input or output.
// - Five control registers: direction, level, latch, analog select, slew rate.
// - Direction one disables the driver; zero drives the latch bit out.
// - Level reads return pin levels; level writes go into the latch.
// - Latch reads return latched values so read-modify-write works on the latch.
// - An enabled peripheral takes over its pin from general-purpose I/O.
// - Pins six and seven are I/O only when the oscillator leaves them free.
// - Analog select bits 5 and 3:0 set mean analog mode; all set at reset.
// - After reset pins 5, 3:0 are analog reading zero; pin 4 digital input.
// - Direction still gates drivers in analog mode; software should keep inputs.
// - Pin four also carries the timer-zero clock input and comparator one output.
// - Comparator controls let pins zero to five serve as comparator pins.
`ifndef PAG_CFG_SVH
`define PAG_CFG_SVH

// ----------------------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------------------
`define PAG_WIDTH 8
`define PAG_SYNC_STAGES 2
`define PAG_PIN_FOUR 4
`define PAG_PIN_FIVE 5
`define PAG_PIN_SIX 6
`define PAG_PIN_SEVEN 7

// ----------------------------------------------------------------------------
// Field masks and reset values
// ----------------------------------------------------------------------------
`define PAG_ANALOG_MASK 8'h2F
`define PAG_COMPARATOR_MASK 8'h3F
`define PAG_DIR_RESET 8'hFF
`define PAG_LATCH_RESET 8'h00
`define PAG_ANALOG_RESET 8'h2F
`define PAG_SLEW_RESET 8'hFF
`define PAG_ZERO_BYTE 8'h00
`define PAG_ALL_ONES 8'hFF

// ----------------------------------------------------------------------------
// Comparator control field: output-to-pin enable
// ----------------------------------------------------------------------------
`define PAG_CMP_OUT_EN_BIT 5

`endif

//--- logic/pag_pkg.sv
// Purpose: Types shared by the port modules.
// Assumes: Included after pag_cfg.svh.
// Notes: Register select codes are the enum defaults, 0 to 4 in listed order.
package pag_pkg;

    // ------------------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        PAG_SEL_DIRECTION,
        PAG_SEL_LEVEL,
        PAG_SEL_LATCH,
        PAG_SEL_ANALOG,
        PAG_SEL_SLEW
    } pag_reg_sel_t;

    typedef logic [7:0] pag_byte_t;

endpackage

//--- logic/pag_pin_if.sv
// Purpose: Carries raw and synchronised pad levels between port modules.
// Assumes: One clock domain on the synchronised side.
// Notes: The core drives raw and reads synced.
`timescale 1ns/1ps
interface pag_pin_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport sync_side (
        input raw,
        output synced
    );
    modport core_side (
        output raw,
        input synced
    );
endinterface

//--- logic/pag_sync.sv
// Purpose: Two-stage synchroniser for the pad input levels.
// Assumes: Pads change asynchronously to core_clk.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`include "pag_cfg.svh"
module pag_sync
    import pag_pkg::*;
#(
    parameter int WIDTH = `PAG_WIDTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    pag_pin_if.sync_side pins
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    always_comb begin
        meta_next = pins.raw;
        stable_next = meta_reg;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign pins.synced = stable_reg;
endmodule

//--- verif/pag_port_sva.sv
// Purpose: Concurrent checks on the general-purpose port outputs.
// Assumes: One clock, core_clk; nrst asynchronous, active low.
// Notes: Bound to pag_port and sees its ports only.
`timescale 1ns/1ps
module pag_port_chk
    import pag_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wr_strobe,
    input wire pag_reg_sel_t wr_sel,
    input wire logic [7:0] wr_data,
    input wire pag_reg_sel_t rd_sel,
    input wire logic [7:0] rd_data,
    input wire logic osc_uses_pin_six,
    input wire logic osc_uses_pin_seven,
    input wire logic [7:0] comparator_one_control,
    input wire logic [7:0] comparator_two_control,
    input wire logic [7:0] periph_enable,
    input wire logic [7:0] periph_drive,
    input wire logic [7:0] periph_drive_en,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_analog_en,
    input wire logic [7:0] pad_comparator_en,
    input wire logic timer_zero_clock_input
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    reset_oe_off_a: assert property ($rose(nrst) && periph_enable == 8'h00 |=> pad_oe == 8'h00)
        else $error("pad drivers enabled straight after reset");
    latch_to_pad_a: assert property ((wr_strobe && wr_sel inside {PAG_SEL_LATCH, PAG_SEL_LEVEL})
        ##1 (periph_enable == 8'h00) |=> ((pad_out ^ $past(wr_data, 2)) & 8'h0F) == 8'h00)
        else $error("latch write did not reach the pad value");
    analog_mask_a: assert property (rd_sel == PAG_SEL_ANALOG
        |=> ((rd_data | pad_analog_en) & 8'hD0) == 8'h00)
        else $error("analog select bit set on a pin without analog mode");
    osc_read_a: assert property (rd_sel inside {PAG_SEL_DIRECTION, PAG_SEL_LEVEL, PAG_SEL_LATCH}
        |=> (rd_data & {$past(osc_uses_pin_seven), $past(osc_uses_pin_six), 6'h00}) == 8'h00)
        else $error("oscillator pin bit read as non-zero");
    osc_drive_a: assert property (osc_uses_pin_six || osc_uses_pin_seven
        |=> (pad_oe & {$past(osc_uses_pin_seven), $past(osc_uses_pin_six), 6'h00}) == 8'h00)
        else $error("port drives a pin owned by the oscillator");
    periph_take_a: assert property (periph_enable != 8'h00
        |=> (((pad_oe ^ $past(periph_drive_en)) | (pad_out ^ $past(periph_drive)))
        & $past(periph_enable) & 8'h3F) == 8'h00)
        else $error("peripheral did not take over its pin");
    cmp_pins_a: assert property (1'b1 |=> pad_comparator_en ==
        (($past(comparator_one_control[5]) || $past(comparator_two_control[5])) ? 8'h3F : 8'h00))
        else $error("comparator pin enables wrong");
    timer_sync_a: assert property ($past(nrst) && $past(nrst, 2)
        |-> timer_zero_clock_input == $past(pad_in[4], 2))
        else $error("timer clock input does not follow pin four");
endmodule

bind pag_port pag_port_chk chk_u (.core_clk, .nrst, .wr_strobe, .wr_sel, .wr_data, .rd_sel, .rd_data,
    .osc_uses_pin_six, .osc_uses_pin_seven, .comparator_one_control, .comparator_two_control,
    .periph_enable, .periph_drive, .periph_drive_en, .pad_in, .pad_out, .pad_oe, .pad_analog_en,
    .pad_comparator_en, .timer_zero_clock_input);

//--- verif/pag_board.sv
// Purpose: Board-side model of the eight port pins.
// Assumes: Every pin has a board level, as if pulled to it.
// Notes: A driven pin shows the port's value, an undriven pin the board level.
`timescale 1ns/1ps
module pag_board (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pad_in
);
    assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the general-purpose port.
// Assumes: core_clk at 200 MHz; reset held for 10 cycles.
// Notes: Reads compare one cycle after rd_sel is taken.
`timescale 1ns/1ps
module testbench;
    import pag_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_strobe = 1'b0;
    pag_reg_sel_t wr_sel = PAG_SEL_LATCH;
    logic [7:0] wr_data = 8'h00;
    pag_reg_sel_t rd_sel = PAG_SEL_LATCH;
    logic osc_six = 1'b0;
    logic osc_seven = 1'b0;
    logic [7:0] cmp_one_ctl = 8'h00;
    logic [7:0] cmp_two_ctl = 8'h00;
    logic cmp_one_out = 1'b0;
    logic cmp_two_out = 1'b0;
    logic [7:0] per_en = 8'h00;
    logic [7:0] per_drv = 8'h00;
    logic [7:0] per_drv_en = 8'h00;
    logic [7:0] ext_level = 8'hFF;
    logic [7:0] rd_data, pad_in, pad_out, pad_oe, pad_analog_en, pad_comparator_en, pad_slew_limit;
    logic timer_clk;
    int fail_count = 0;
    int checked = 0;

    always #2.5 core_clk = ~core_clk;

    pag_port dut_u (.core_clk(core_clk), .nrst(nrst), .wr_strobe(wr_strobe), .wr_sel(wr_sel),
        .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data), .osc_uses_pin_six(osc_six),
        .osc_uses_pin_seven(osc_seven), .comparator_one_control(cmp_one_ctl),
        .comparator_two_control(cmp_two_ctl), .comparator_one_output(cmp_one_out),
        .comparator_two_output(cmp_two_out),
        .periph_enable(per_en), .periph_drive(per_drv), .periph_drive_en(per_drv_en), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog_en(pad_analog_en),
        .pad_comparator_en(pad_comparator_en), .pad_slew_limit(pad_slew_limit),
        .timer_zero_clock_input(timer_clk));
    pag_board board_u (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input pag_reg_sel_t sel, input logic [7:0] data);
        @(posedge core_clk);
        wr_strobe <= 1'b1;
        wr_sel <= sel;
        wr_data <= data;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input pag_reg_sel_t sel, input logic [7:0] exp);
        @(posedge core_clk);
        rd_sel <= sel;
        @(posedge core_clk);
        #1;
        chk(rd_data, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        wait_cyc(1);
        chk(pad_oe, 8'h00);
        rd(PAG_SEL_DIRECTION, 8'hFF);
        rd(PAG_SEL_LATCH, 8'h00);
        rd(PAG_SEL_ANALOG, 8'h2F);
        rd(PAG_SEL_SLEW, 8'hFF);
        rd(PAG_SEL_LEVEL, 8'hD0);
        wr(PAG_SEL_ANALOG, 8'hFF);
        rd(PAG_SEL_ANALOG, 8'h2F);
        wr(PAG_SEL_ANALOG, 8'h00);
        ext_level <= 8'hA5;
        wr(PAG_SEL_LEVEL, 8'hC3);
        rd(PAG_SEL_LATCH, 8'hC3);
        wait_cyc(3);
        rd(PAG_SEL_LEVEL, 8'hA5);
        chk({7'h00, timer_clk}, 8'h00);
        // Analog mode is back on while the pins are turned into outputs.
        wr(PAG_SEL_ANALOG, 8'h2F);
        wr(PAG_SEL_DIRECTION, 8'h00);
        wr(PAG_SEL_LATCH, 8'h5A);
        wait_cyc(2);
        chk(pad_oe, 8'hFF);
        chk(pad_out, 8'h5A);
        wait_cyc(3);
        rd(PAG_SEL_LEVEL, 8'h50);
        chk({7'h00, timer_clk}, 8'h01);
        rd(PAG_SEL_LATCH, 8'h5A);
        @(posedge core_clk);
        osc_six <= 1'b1;
        osc_seven <= 1'b1;
        rd(PAG_SEL_LATCH, 8'h1A);
        chk(pad_oe, 8'h3F);
        // Pin seven now floats to its board level, which must still read as zero.
        rd(PAG_SEL_LEVEL, 8'h10);
        @(posedge core_clk);
        per_en <= 8'h02;
        per_drv_en <= 8'h00;
        wait_cyc(2);
        chk(pad_out & 8'h3F, 8'h18);
        chk(pad_oe, 8'h3D);
        @(posedge core_clk);
        cmp_one_ctl <= 8'h20;
        wait_cyc(2);
        chk(pad_comparator_en, 8'h3F);
        chk(pad_out & 8'h3F, 8'h08);
        @(posedge core_clk);
        cmp_one_out <= 1'b1;
        cmp_two_ctl <= 8'h20;
        cmp_two_out <= 1'b1;
        wait_cyc(2);
        chk(pad_out & 8'h3F, 8'h38);
        @(posedge core_clk);
        cmp_one_ctl <= 8'h00;
        cmp_two_out <= 1'b0;
        wait_cyc(2);
        chk(pad_comparator_en, 8'h3F);
        chk(pad_out & 8'h3F, 8'h18);
        wr(PAG_SEL_SLEW, 8'h0F);
        rd(PAG_SEL_SLEW, 8'h0F);
        chk(pad_slew_limit, 8'h0F);
        @(posedge core_clk);
        nrst <= 1'b0;
        wait_cyc(2);
        chk(pad_oe, 8'h00);
        chk(pad_analog_en, 8'h2F);
        chk(pad_slew_limit, 8'hFF);
        @(posedge core_clk);
        nrst <= 1'b1;
        rd(PAG_SEL_DIRECTION, 8'h3F);
        close_out;
    end

    initial begin
        repeat (2000) @(posedge core_clk);
        fail_count++;
        close_out;
    end
endmodule
